// ===== logic/slot_payload_keystream_xor.sv
// key stream xor datapath for one full-slot payload field per direction
//
// Overview of operation
// (R01) field is 388 bits: 64-bit first part then 324-bit second part
// (R02) first part is 8-bit header, 40-bit tail, 16-bit check
// (R03) second part is 320-bit data area then 4-bit check
// (R04) tail type and second-part mux content are decoded from header codes
// (R05) four-subfield format: each 80-bit subfield ends in a 16-bit check
// (R06) single-subfield format: 304 data bits with one 16-bit check
// (R07) control and protected user use four-subfield; quality uses single
// (R08) header and first-part check untouched; tail only when control type
// (R09) second-part checks never changed; every data bit is xored
// (R10) two 360-bit segments per frame, bit 0 first from generator
// (R11) control tail: segment bits 0..39 xor onto a8..a47
// (R12) other tail: segment bits 0..39 dropped, tail untouched
// (R13) unprotected: segment bits 40..359 xor onto b0..b319
// (R14) single-subfield: segment 40..343 onto b0..b303; rest unused
// (R15) four-subfield: 64-bit windows at 40,120,200,280 onto b0,b80,b160,b240
// (R16) same xor mapping serves transmit and receive fields
// (R17) checks are made and verified outside, over encrypted content
// (R18) generator restarts each frame from frame and multiframe number
// (R19) first segment serves fixed-to-portable, second the reverse
// (R20) clear mode passes fields unchanged and takes no key stream
// (R21) keys applied only after all 720 bits of the pair arrived
`timescale 1ns/100ps
module slot_payload_keystream_xor #(
   parameter int CNT_W = 10
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rstn,
   input  wire logic                     clk_en,
   input  wire logic                     clear_mode,
   input  wire logic                     fixed_end,
   input  wire slot_crypt_pkg::service_t service,
   input  wire logic                     frame_start,
   input  wire logic                     ks_valid,
   input  wire logic                     ks_bit,
   output logic                          ks_ready,
   output logic                          keys_ready,
   output logic                          keys_spent,
   input  wire slot_crypt_pkg::field_req_t fld_in,
   output slot_crypt_pkg::field_rsp_t    fld_out,
   output logic                          fld_err
);
   import slot_crypt_pkg::*;

   // ***********************************************************
   // elaboration checks
   // ***********************************************************
   if ((2 ** CNT_W) < PAIR_BITS) begin : g_cnt_chk
      $error("CNT_W too narrow for the key stream pair count");
   end

   localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(PAIR_BITS - 1);
   // width of the tail type and mux codes in the header
   localparam int HDR_CODE_W = $bits(TAIL_CTRL_CODE);

   // both parts must fill the whole field exactly
   if (APART_BITS + BPART_BITS != FIELD_BITS) begin : g_field_chk
      $error("first and second part do not fill the field"); // [R01]
   end

   // header, tail and first-part check fill the first part
   if (HDR_BITS + TAIL_BITS + ACHK_BITS != APART_BITS) begin : g_apart_chk
      $error("first part layout does not add up");          // [R02]
   end

   // tail follows the header and the check follows the tail
   if (TAIL_LSB != HDR_LSB + HDR_BITS ||
       ACHK_LSB != TAIL_LSB + TAIL_BITS) begin : g_apos_chk
      $error("first part positions overlap");               // [R02]
   end

   // data area and 4-bit check fill the second part
   if (DATA_BITS + BCHK_BITS != BPART_BITS ||
       BCHK_LSB != DATA_LSB + DATA_BITS) begin : g_bpart_chk
      $error("second part layout does not add up");         // [R03]
   end

   // four equal subfields, each data then its own check
   if (DATA_BITS % SUB_STRIDE != 0 ||
       SUB_DATA + SUB_CHK != SUB_STRIDE) begin : g_sub_chk
      $error("four-subfield layout does not add up");       // [R05]
   end

   // single subfield leaves room for exactly one check
   if (SINGLE_DATA + SUB_CHK != DATA_BITS) begin : g_single_chk
      $error("single-subfield layout does not add up");     // [R06]
   end

   // segment: tail window then one bit per data-area bit
   if (SEG_TAIL_LSB + TAIL_BITS != SEG_DATA_LSB ||
       SEG_DATA_LSB + DATA_BITS != SEG_BITS) begin : g_seg_chk
      $error("segment windows do not match the field");     // [R11] [R13]
   end

   // the pair is two whole segments
   if (SEG_BITS + SEG_BITS != PAIR_BITS) begin : g_pair_chk
      $error("pair is not two segments");                   // [R10]
   end

   // both header codes must sit inside the header
   if (HDR_TAIL_POS + HDR_CODE_W > HDR_BITS ||
       HDR_MUX_POS + HDR_CODE_W > HDR_BITS) begin : g_code_chk
      $error("header code outside the header");             // [R04]
   end

   // ***********************************************************
   // functions
   // ***********************************************************

   // pick second-part format from header mux code and service
   function automatic bformat_t pick_format(input logic [HDR_BITS-1:0] h,
                                            input service_t svc);
      logic [HDR_CODE_W-1:0] mux;
      bformat_t   f;
      mux = h[HDR_MUX_POS +: HDR_CODE_W];
      if (mux != MUX_U_CODE) begin
         f = fmt_four_sub;                       // [R04] [R07]
      end else if (svc == svc_quality) begin
         f = fmt_single_sub;                     // [R07]
      end else if (svc == svc_protected) begin
         f = fmt_four_sub;                       // [R07]
      end else begin
         f = fmt_unprotected;                    // [R07]
      end
      return f;
   endfunction

   // data-area bit j carries data (not a check) in format f
   function automatic logic is_data_bit(input bformat_t f,
                                        input int j);
      logic d;
      case (f)
         fmt_unprotected: d = 1'b1;                      // [R13]
         fmt_single_sub:  d = (j < SINGLE_DATA);         // [R06] [R14]
         fmt_four_sub:    d = ((j % SUB_STRIDE) < SUB_DATA); // [R05] [R15]
         default:         d = 1'b0;
      endcase
      return d;
   endfunction

   // full xor mask for one field from one segment
   function automatic logic [FIELD_BITS-1:0] build_mask(
      input logic [SEG_BITS-1:0]  seg,
      input logic                 ctrl_tail,
      input bformat_t             f);
      logic [FIELD_BITS-1:0] m;
      m = '0;                                    // header, checks stay 0 [R08]
      if (ctrl_tail) begin
         for (int i = 0; i < TAIL_BITS; i++) begin
            m[TAIL_LSB + i] = seg[SEG_TAIL_LSB + i]; // [R11]
         end
      end                                        // else bits 0..39 dropped [R12]
      for (int j = 0; j < DATA_BITS; j++) begin
         // segment bit 40+j pairs with b_j in every format
         if (is_data_bit(f, j)) begin
            m[DATA_LSB + j] = seg[SEG_DATA_LSB + j]; // [R09] [R13] [R14] [R15]
         end
      end
      // second-part and subfield check bits left at zero [R09] [R17]
      return m;
   endfunction

   // ***********************************************************
   // key collection state
   // ***********************************************************
   typedef enum logic [1:0] {
      st_idle,     // clear mode or waiting for a frame start
      st_fill,     // shifting in the 720-bit pair
      st_hold      // pair complete and usable
   } kstate_t;

   kstate_t               state_ff;
   logic [CNT_W-1:0]      cnt_ff;
   logic [PAIR_BITS-1:0]  pair_ff;
   logic                  ks_ready_ff;
   logic                  keys_ready_ff;
   logic                  tx_used_ff;
   logic                  rx_used_ff;
   logic                  keys_spent_ff;
   field_rsp_t            fld_out_ff;
   logic                  fld_err_ff;

   logic                  ks_take;
   logic                  last_take;
   logic                  fld_take;
   logic                  use_second;
   logic                  dir_used;
   logic                  fld_ok;
   logic [SEG_BITS-1:0]   seg_sel;
   logic [HDR_BITS-1:0]   hdr;
   logic                  ctrl_tail;
   bformat_t              fmt;
   logic [FIELD_BITS-1:0] mask;

   // ***********************************************************
   // request decode
   // ***********************************************************

   // key bit and field acceptance strobes
   assign ks_take   = clk_en && ks_valid && ks_ready_ff;
   assign last_take = ks_take && (cnt_ff == LAST_BIT);
   assign fld_take  = clk_en && fld_in.valid;

   // fixed end: tx first segment, rx second; portable the reverse
   assign use_second = fixed_end ? fld_in.rx_dir : !fld_in.rx_dir; // [R19]
   assign seg_sel    = use_second ? pair_ff[SEG_BITS +: SEG_BITS]
                                  : pair_ff[0 +: SEG_BITS];        // [R10]
   assign dir_used   = fld_in.rx_dir ? rx_used_ff : tx_used_ff;

   // header decode of tail type and second part format
   assign hdr       = fld_in.data[HDR_LSB +: HDR_BITS];            // [R02]
   assign ctrl_tail = (hdr[HDR_TAIL_POS +: HDR_CODE_W] ==
                       TAIL_CTRL_CODE);                           // [R04]
   assign fmt       = pick_format(hdr, service);
   assign mask      = build_mask(seg_sel, ctrl_tail, fmt);

   // encrypt mode needs a full unspent pair for this direction
   assign fld_ok = clear_mode || (keys_ready_ff && !dir_used);     // [R21]

   // ***********************************************************
   // key stream collection
   // ***********************************************************

   // state and bit counter of the key pair
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= st_idle;
         cnt_ff   <= '0;
      end else if (clk_en) begin
         if (clear_mode) begin
            state_ff <= st_idle;                 // no key stream used [R20]
            cnt_ff   <= '0;
         end else if (frame_start) begin
            state_ff <= st_fill;                 // new pair every frame [R18]
            cnt_ff   <= '0;
         end else if (last_take) begin
            state_ff <= st_hold;
            cnt_ff   <= '0;
         end else if (ks_take) begin
            cnt_ff   <= cnt_ff + CNT_W'(1);
         end
      end
   end

   // key pair store, bit n lands at index n
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pair_ff <= '0;
      end else if (ks_take && !clear_mode && !frame_start) begin
         pair_ff[cnt_ff] <= ks_bit;              // [R10]
      end
   end

   // handshake towards the generator
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ks_ready_ff <= 1'b0;
      end else if (clk_en) begin
         if (clear_mode) begin
            ks_ready_ff <= 1'b0;                 // [R20]
         end else if (frame_start) begin
            ks_ready_ff <= 1'b1;
         end else if (last_take) begin
            ks_ready_ff <= 1'b0;                 // exactly 720 bits taken
         end
      end
   end

   // pair complete flag
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         keys_ready_ff <= 1'b0;
      end else if (clk_en) begin
         if (clear_mode || frame_start) begin
            keys_ready_ff <= 1'b0;
         end else if (last_take) begin
            keys_ready_ff <= 1'b1;               // only after full pair [R21]
         end
      end
   end

   // ***********************************************************
   // per-direction use of the pair
   // ***********************************************************

   // each segment is applied to one field per frame
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tx_used_ff <= 1'b0;
         rx_used_ff <= 1'b0;
      end else if (clk_en) begin
         if (clear_mode || frame_start) begin
            tx_used_ff <= 1'b0;
            rx_used_ff <= 1'b0;
         end else if (fld_take && fld_ok) begin
            if (fld_in.rx_dir) begin
               rx_used_ff <= 1'b1;
            end else begin
               tx_used_ff <= 1'b1;
            end
         end
      end
   end

   // both segments applied this frame
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         keys_spent_ff <= 1'b0;
      end else if (clk_en) begin
         keys_spent_ff <= !clear_mode && !frame_start &&
                          tx_used_ff && rx_used_ff;
      end
   end

   // ***********************************************************
   // xor datapath
   // ***********************************************************

   // one path for both directions; result one cycle after the strobe
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fld_out_ff <= '0;
      end else if (clk_en) begin
         fld_out_ff.valid  <= fld_take && fld_ok;
         fld_out_ff.rx_dir <= fld_in.rx_dir;
         if (fld_take && fld_ok) begin
            if (clear_mode) begin
               fld_out_ff.data <= fld_in.data;   // pass through [R20]
            end else begin
               fld_out_ff.data <= fld_in.data ^ mask; // [R16] [R01] [R03]
            end
         end
      end
   end

   // refusal of a field with no usable keys
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fld_err_ff <= 1'b0;
      end else if (clk_en) begin
         fld_err_ff <= fld_take && !fld_ok;      // no partial pair used [R21]
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign ks_ready   = ks_ready_ff;
   assign keys_ready = keys_ready_ff;
   assign keys_spent = keys_spent_ff;
   assign fld_out    = fld_out_ff;
   assign fld_err    = fld_err_ff;

endmodule

// ===== logic/slot_crypt_pkg.sv
// shared constants and carrier types for the slot payload key stream xor
package slot_crypt_pkg;

   // ***********************************************************
   // field layout of the slot payload field
   // ***********************************************************
   localparam int FIELD_BITS   = 388;   // whole slot payload field
   localparam int APART_BITS   = 64;    // first part
   localparam int BPART_BITS   = 324;   // second part
   localparam int HDR_LSB      = 0;     // header a0..a7
   localparam int HDR_BITS     = 8;
   localparam int TAIL_LSB     = 8;     // tail a8..a47
   localparam int TAIL_BITS    = 40;
   localparam int ACHK_LSB     = 48;    // first part check a48..a63
   localparam int ACHK_BITS    = 16;
   localparam int DATA_LSB     = 64;    // data area b0..b319
   localparam int DATA_BITS    = 320;
   localparam int BCHK_LSB     = 384;   // 4-bit second part check
   localparam int BCHK_BITS    = 4;
   localparam int SUB_STRIDE   = 80;    // four-subfield spacing
   localparam int SUB_DATA     = 64;    // data bits per subfield
   localparam int SUB_CHK      = 16;    // check bits per subfield
   localparam int SINGLE_DATA  = 304;   // single-subfield data bits

   // ***********************************************************
   // key stream layout
   // ***********************************************************
   localparam int SEG_BITS     = 360;   // one key stream segment
   localparam int PAIR_BITS    = 720;   // both segments of a frame
   localparam int SEG_TAIL_LSB = 0;     // segment bits 0..39 for tail
   localparam int SEG_DATA_LSB = 40;    // segment bit 40 pairs with b0

   // ***********************************************************
   // header codes
   // ***********************************************************
   localparam int       HDR_TAIL_POS  = 5;      // tail type code a5..a7
   localparam int       HDR_MUX_POS   = 1;      // mux code a1..a3
   localparam logic [2:0] TAIL_CTRL_CODE = 3'h6; // control tail type
   localparam logic [2:0] MUX_U_CODE    = 3'h0; // user-type second part

   // ***********************************************************
   // enumerations
   // ***********************************************************
   typedef enum logic [1:0] {
      svc_unprotected,   // unprotected user channel
      svc_protected,     // protected user channel
      svc_quality        // quality_user_channel service
   } service_t;

   typedef enum logic [1:0] {
      fmt_unprotected,   // unprotected_mapping
      fmt_four_sub,      // protected_user / protected_control mapping
      fmt_single_sub     // single_subfield_mapping
   } bformat_t;

   // ***********************************************************
   // carriers
   // ***********************************************************
   typedef struct packed {
      logic                  valid;    // one-cycle field strobe
      logic                  rx_dir;   // 1: received field, 0: transmit
      logic [FIELD_BITS-1:0] data;     // bit 0 is a0
   } field_req_t;

   typedef struct packed {
      logic                  valid;    // one-cycle result strobe
      logic                  rx_dir;   // direction echoed
      logic [FIELD_BITS-1:0] data;     // processed field
   } field_rsp_t;

endpackage

// ===== verification/slot_payload_keystream_xor_asserts.sv
// port checker for the slot payload key stream xor block
`timescale 1ns/100ps
module slot_xor_checker #(
   parameter int CNT_W = 10
) (
   input wire logic                       ref_clk,
   input wire logic                       rstn,
   input wire logic                       clk_en,
   input wire logic                       clear_mode,
   input wire logic                       fixed_end,
   input wire slot_crypt_pkg::service_t   service,
   input wire logic                       frame_start,
   input wire logic                       ks_valid,
   input wire logic                       ks_bit,
   input wire logic                       ks_ready,
   input wire logic                       keys_ready,
   input wire logic                       keys_spent,
   input wire slot_crypt_pkg::field_req_t fld_in,
   input wire slot_crypt_pkg::field_rsp_t fld_out,
   input wire logic                       fld_err
);
   import slot_crypt_pkg::*;
   logic [CNT_W-1:0] bit_cnt_ff;
   // ***************************************************
   // key bits taken since the last frame start or clear mode
   // ***************************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_ff <= '0;
      end else if (clk_en && (frame_start || clear_mode)) begin
         bit_cnt_ff <= '0;
      end else if (clk_en && ks_valid && ks_ready) begin
         bit_cnt_ff <= bit_cnt_ff + 1'b1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // field taken, and a good answer to it
   sequence s_take; clk_en && fld_in.valid; endsequence
   sequence s_out; fld_out.valid && !fld_err; endsequence
   AST_ANSWER: assert property (s_take |=> fld_out.valid != fld_err)
      else $error("field not answered exactly once");
   AST_CLEAR_PASS: assert property (s_take ##0 clear_mode |=> s_out
      ##0 fld_out.data == $past(fld_in.data))
      else $error("clear mode altered the field");
   AST_HDR_KEEP: assert property (s_take |=> !fld_out.valid ||
      (fld_out.data[7:0] == $past(fld_in.data[7:0]) &&
       fld_out.data[63:48] == $past(fld_in.data[63:48])))
      else $error("header or first part check altered");
   AST_XCHK_KEEP: assert property (s_take |=> !fld_out.valid ||
      fld_out.data[387:384] == $past(fld_in.data[387:384]))
      else $error("second part check altered");
   AST_TAIL_KEEP: assert property (s_take ##0
      fld_in.data[7:5] != TAIL_CTRL_CODE |=> !fld_out.valid ||
      fld_out.data[47:8] == $past(fld_in.data[47:8]))
      else $error("non control tail altered");
   AST_KEYS_FULL: assert property ($rose(keys_ready) |->
      int'(bit_cnt_ff) == PAIR_BITS && !ks_ready)
      else $error("keys ready before the whole pair");
   AST_COLLECT: assert property (clk_en && frame_start &&
      !clear_mode |=> ks_ready && !keys_ready)
      else $error("collection did not start");
   AST_REFUSE: assert property (s_take ##0 !clear_mode && !keys_ready
      |=> fld_err && !fld_out.valid)
      else $error("field accepted without keys");
endmodule
bind slot_payload_keystream_xor slot_xor_checker #(.CNT_W(CNT_W))
   slot_xor_checker_i (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
   .clear_mode(clear_mode), .fixed_end(fixed_end), .service(service),
   .frame_start(frame_start), .ks_valid(ks_valid), .ks_bit(ks_bit),
   .ks_ready(ks_ready), .keys_ready(keys_ready), .keys_spent(keys_spent),
   .fld_in(fld_in), .fld_out(fld_out), .fld_err(fld_err));

// ===== verification/keystream_gen_model.sv
// behavioural key stream generator feeding the xor block
`timescale 1ns/100ps
module keystream_gen_model (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        frame_start,
   input  wire logic        ks_ready,
   input  wire logic        slow,
   input  wire logic [3:0]  frame_num,
   input  wire logic [23:0] mframe_num,
   output logic             ks_valid,
   output logic             ks_bit,
   output logic [719:0]     pair_bits
);
   logic [34:0] lfsr_ff;
   int          idx_ff;
   logic        vld, tog;
   initial begin
      ks_valid = 1'b0;
      ks_bit = 1'b0;
      tog = 1'b0;
   end
   // restart per frame from the initial value, step on each bit taken
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         lfsr_ff <= '0;
         idx_ff <= 0;
      end else if (frame_start) begin
         lfsr_ff <= {7'h00, mframe_num, frame_num} ^ 35'h2_4924_9249;
         idx_ff <= 0;
      end else if (ks_valid && ks_ready) begin
         pair_bits[idx_ff] <= lfsr_ff[0];
         lfsr_ff <= {lfsr_ff[0] ^ lfsr_ff[2], lfsr_ff[34:1]};
         idx_ff <= idx_ff + 1;
      end
   end
   // offer bits at the falling edge; slow mode idles every other cycle
   always @(negedge ref_clk) begin
      vld = ks_ready && idx_ff < 720 && !(slow && tog);
      tog = !tog;
      ks_valid <= vld;
      ks_bit <= vld ? lfsr_ff[0] : !ks_bit; // idle line toggles
   end
endmodule

// ===== verification/tb.sv
// self-checking bench for the slot payload key stream xor
`timescale 1ns/100ps
module tb;
   import slot_crypt_pkg::*;
   logic ref_clk, rstn, clk_en, clear_mode, fixed_end, frame_start;
   logic ks_valid, ks_bit, ks_ready, keys_ready, keys_spent, fld_err, slow;
   logic [3:0]            frame_num;
   logic [719:0]          pair_bits;
   logic [FIELD_BITS-1:0] pat, d;
   logic [SEG_BITS-1:0]   seg;
   service_t              service;
   field_req_t            fld_in;
   field_rsp_t            fld_out;
   int                    error_cnt, n_compared;
   slot_payload_keystream_xor #(.CNT_W(10)) slot_payload_keystream_xor_i (
      .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
      .clear_mode(clear_mode), .fixed_end(fixed_end), .service(service),
      .frame_start(frame_start), .ks_valid(ks_valid), .ks_bit(ks_bit),
      .ks_ready(ks_ready), .keys_ready(keys_ready), .keys_spent(keys_spent),
      .fld_in(fld_in), .fld_out(fld_out), .fld_err(fld_err));
   keystream_gen_model keystream_gen_model_i (.ref_clk(ref_clk), .rstn(rstn),
      .frame_start(frame_start), .ks_ready(ks_ready), .slow(slow),
      .frame_num(frame_num), .mframe_num(24'h00_0a5c),
      .ks_valid(ks_valid), .ks_bit(ks_bit), .pair_bits(pair_bits));
   always #12.5 ref_clk = ~ref_clk;
   // ***************************************************
   // helpers
   // ***************************************************
   task automatic final_report();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [FIELD_BITS-1:0] e, got);
      n_compared++;
      if (got !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, got);
      end
   endtask
   // expected field after the key stream mask
   function automatic logic [FIELD_BITS-1:0] xmask(
      logic [FIELD_BITS-1:0] f, logic [SEG_BITS-1:0] s, service_t sv);
      logic four, one, ctl;
      four = f[3:1] != 3'h0 || sv == svc_protected;
      one = f[3:1] == 3'h0 && sv == svc_quality;
      ctl = f[7:5] == 3'h6;
      for (int i = 0; i < 40; i++) f[8+i] = f[8+i] ^ (ctl & s[i]);
      for (int j = 0; j < 320; j++) f[64+j] = f[64+j] ^ (s[40+j] &
         (four ? j % 80 < 64 : (one ? j < 304 : 1'b1)));
      return f;
   endfunction
   // frame start pulse, then wait for the whole pair
   task automatic load_keys(logic [3:0] fn, logic sl);
      int n;
      @(negedge ref_clk);
      frame_num = fn;
      slow = sl;
      frame_start = 1'b1;
      @(negedge ref_clk);
      frame_start = 1'b0;
      chk("ks_ready", 1, ks_ready);
      for (n = 0; keys_ready !== 1'b1 && n < 2000; n++) @(negedge ref_clk);
      chk("keys_ready", 2'b10, {keys_ready, ks_ready});
      if (!sl) chk("bit_cycles", 720, n);
      if (n >= 2000) final_report();
   endtask
   task automatic send(logic rx, logic [FIELD_BITS-1:0] f, logic ok,
                       logic [FIELD_BITS-1:0] e);
      @(negedge ref_clk);
      fld_in = '{valid: 1'b1, rx_dir: rx, data: f};
      @(negedge ref_clk);
      fld_in.valid = 1'b0;
      chk("fld_err", !ok, fld_err);
      chk("fld_valid", {ok, rx}, {fld_out.valid, fld_out.rx_dir & ok});
      if (ok) chk("fld_data", e, fld_out.data);
   endtask
   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      {ref_clk, rstn, clear_mode, frame_start, slow} = '0;
      {clk_en, fixed_end} = 2'b11;
      service = svc_unprotected;
      frame_num = '0;
      fld_in = '0;
      error_cnt = 0;
      n_compared = 0;
      pat = {{12{32'h96e1_5a3c}}, 4'h9};
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      rstn = 1'b1;
      chk("idle", 0, {ks_ready, keys_ready, keys_spent, fld_out.valid});
      send(0, pat, 0, 0);
      for (int k = 0; k < 4; k++) begin
         fixed_end = k[1];
         service = service_t'(k % 3);
         load_keys(4'(k), k[0]);
         for (int r = 0; r < 2; r++) begin
            d = pat;
            d[7:5] = (r ^ k[0]) ? 3'h6 : 3'(k);
            d[3:1] = k == 3 ? 3'h5 : 3'h0;
            seg = (fixed_end == (r[0] ^ k[0])) ? pair_bits[719:360] :
                  pair_bits[359:0];
            send(r[0] ^ k[0], d, 1, xmask(d, seg, service));
         end
         @(negedge ref_clk);
         chk("keys_spent", 1, keys_spent);
         send(0, pat, 0, 0);
      end
      // clear mode: a frame start must not start key collection
      clear_mode = 1'b1;
      @(negedge ref_clk);
      frame_start = 1'b1;
      @(negedge ref_clk);
      frame_start = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("clear_keys", 0, {ks_ready, keys_ready, keys_spent});
      send(1, d, 1, d);
      // clock enable low: field ignored, outputs frozen
      @(negedge ref_clk);
      clk_en = 1'b0;
      fld_in = '{valid: 1'b1, rx_dir: 1'b0, data: pat};
      @(negedge ref_clk);
      fld_in.valid = 1'b0;
      clk_en = 1'b1;
      chk("frozen", 3'b001, {fld_out.valid, fld_err, fld_out.rx_dir});
      final_report();
   end
endmodule
